// file: core/ursb_top.sv
// Serial receive path with break transmission and flag handling
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "ursb_defines.svh"
//
// Behaviour
// - Status read then data write clears transmit-empty and idle flags.
// - Break bit held over divisor+1 clocks while idle arms a break.
// - Break is start bit, 13*N zero bits, then stop bits.
// - Break sending never raises the transmit-empty interrupt.
// - Breaks repeat while bit held; after clearing, finish then stop bits.
// - Nine-bit mode puts top received bit into ninth receive bit.
// - Recovery at 16x baud, three-sample majority, one shift per bit.
// - Bits shift in LSB first; shifter has no software access.
// - After the stop sample, word moves to buffer if space.
// - Two-word buffer; third completing early sets overrun, drops word.
// - Setting receive enable starts the start bit hunt.
// - Word entry sets data-available; transfer or overrun interrupts.
// - Data, overrun, noise flags clear by status read then data read.
// - Break received: framing error, zeros loaded, idle set.
// - After break, wait for high line before next start hunt.
// - Receiver idle low from start bit mid-sample until stop read.
// - Noise sets its flag with data-available, no own interrupt.
// - Zero in stop position sets framing error.
// - Parity error checked and stored with each word.
// - Receiver checks a single stop bit always.
// - Port disable empties buffer and sets flags to defined state.
module ursb_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Serial pins
    input wire logic rx_i,
    output logic tx_o,
    // Interrupts
    output logic rx_irq_o,
    output logic tx_irq_o
);
    // ------------------------------------------------------------
    // Registers and pin synchroniser
    // ------------------------------------------------------------
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] baud_divisor;
    logic [2:0] rx_sync;
    logic rx_line;
    logic [7:0] div_cnt;
    logic ovs_tick;
    logic stat_seen;
    logic transmit_empty_flag;
    logic transmitter_idle_flag;
    logic receiver_idle_flag;
    logic overrun_flag;
    // Buffer entries: 9 data, noise, framing, parity
    // Slot 0 is the head; a pop moves slot 1 down in the same cycle
    logic [11:0] fifo [0:1];
    logic [1:0] fifo_cnt;
    logic port_enable;
    logic receive_enable;
    logic break_send_ctl;
    logic nine_bit_format;
    logic receive_irq_enable;

    assign port_enable = ctrl1[`URSB_C1_EN];
    assign nine_bit_format = ctrl1[`URSB_C1_NINE];
    assign break_send_ctl = ctrl1[`URSB_C1_BRK];
    assign receive_enable = ctrl2[`URSB_C2_RECEIVE_ENABLE] & port_enable;
    assign receive_irq_enable = ctrl2[`URSB_C2_RIE];

    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction : maj3

    // A change counts once the second and third stages agree
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            rx_sync <= 3'h7;
            rx_line <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_i};
            if (rx_sync[1] == rx_sync[2])
                rx_line <= rx_sync[2];
        end
    end

    // 16x tick: divisor+1 clocks per tick
    wire div_wrap = (div_cnt == baud_divisor);
    wire [7:0] next_div = div_wrap ? 8'h00 : div_cnt + 8'h01;
    always_ff @(posedge mclk_i) begin
        if (!rstn_i || !port_enable) begin
            div_cnt <= 8'h00;
            ovs_tick <= 1'b0;
        end else begin
            div_cnt <= next_div;
            ovs_tick <= div_wrap;
        end
    end

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    wire wr_stat = wr_i && addr_i == `URSB_ADDR_STATUS;
    wire wr_data = wr_i && addr_i == `URSB_ADDR_DATA;
    wire rd_stat = rd_i && addr_i == `URSB_ADDR_STATUS;
    wire rd_data = rd_i && addr_i == `URSB_ADDR_DATA;
    wire seq_rd_data = rd_data && stat_seen;
    wire seq_wr_data = wr_data && stat_seen;
    wire pop = seq_rd_data && fifo_cnt != 2'h0;
    wire fifo_empty = (fifo_cnt == 2'h0);
    wire [7:0] status_word = {1'b0, fifo[0][9] & ~fifo_empty,
        fifo[0][10] & ~fifo_empty, fifo[0][11] & ~fifo_empty, overrun_flag,
        receiver_idle_flag, transmitter_idle_flag, transmit_empty_flag};
    // Status layout: 7 rsv,6 noise,5 frame,4 parity,3 ovr,2 receiver_idle_flag,1 transmitter_idle_flag,0 txe
    wire avail = ~fifo_empty;

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    ursb_pkg::ursb_rx_t rx_st;
    logic [3:0] ovs_cnt;
    logic [3:0] bit_idx;
    logic [8:0] receive_shift_reg;
    logic [2:0] samp;
    logic noise_acc;
    logic par_acc;
    logic load_word;
    logic [11:0] load_val;
    // The vote sees the three ticks before the middle count: one short
    // glitch is outvoted, yet still marks the word as noisy
    wire vote = maj3(samp);
    wire samp_noise = ~(samp == 3'h0 || samp == 3'h7);
    wire [3:0] n_data = nine_bit_format ? 4'h9 : 4'h8;
    wire par_en = ctrl1[`URSB_C1_PAREN];
    wire par_bad = par_acc ^ ctrl1[`URSB_C1_PODD];
    wire [8:0] shift_in = nine_bit_format ?
        {vote, receive_shift_reg[8:1]} : {1'b0, vote, receive_shift_reg[7:1]};

    always_ff @(posedge mclk_i) begin
        if (!rstn_i || !receive_enable) begin
            rx_st <= ursb_pkg::RX_OFF;
            ovs_cnt <= 4'h0;
            bit_idx <= 4'h0;
            receive_shift_reg <= 9'h000;
            samp <= 3'h7;
            noise_acc <= 1'b0;
            par_acc <= 1'b0;
            load_word <= 1'b0;
            load_val <= 12'h000;
        end else begin
            load_word <= 1'b0;
            if (ovs_tick)
                samp <= {samp[1:0], rx_line};
            case (rx_st)
                ursb_pkg::RX_OFF: rx_st <= ursb_pkg::RX_HUNT;
                ursb_pkg::RX_HUNT: if (ovs_tick && !rx_line) begin
                    rx_st <= ursb_pkg::RX_START;
                    ovs_cnt <= 4'h0;
                end
                ursb_pkg::RX_START: if (ovs_tick) begin
                    ovs_cnt <= ovs_cnt + 4'h1;
                    if (ovs_cnt == `URSB_OVS_MID) begin
                        if (vote) begin
                            rx_st <= ursb_pkg::RX_HUNT;
                        end else begin
                            noise_acc <= samp_noise;
                            par_acc <= 1'b0;
                            bit_idx <= 4'h0;
                        end
                    end
                    if (ovs_cnt == `URSB_OVS_LAST)
                        rx_st <= ursb_pkg::RX_DATA;
                end
                ursb_pkg::RX_DATA: if (ovs_tick) begin
                    ovs_cnt <= ovs_cnt + 4'h1;
                    if (ovs_cnt == `URSB_OVS_MID) begin
                        receive_shift_reg <= shift_in;
                        noise_acc <= noise_acc | samp_noise;
                        par_acc <= par_acc ^ vote;
                        bit_idx <= bit_idx + 4'h1;
                    end
                    if (ovs_cnt == `URSB_OVS_LAST && bit_idx == n_data)
                        rx_st <= ursb_pkg::RX_STOP;
                end
                ursb_pkg::RX_STOP: if (ovs_tick) begin
                    ovs_cnt <= ovs_cnt + 4'h1;
                    // One stop bit only on receive
                    if (ovs_cnt == `URSB_OVS_MID) begin
                        load_word <= 1'b1;
                        // A framed word keeps its bits; a break has
                        // shifted in nothing but zeros already
                        load_val <= {par_en & par_bad, ~vote,
                            noise_acc | samp_noise,
                            receive_shift_reg};
                        if (!vote && receive_shift_reg == 9'h000)
                            rx_st <= ursb_pkg::RX_WAITHI;
                        else if (!vote)
                            rx_st <= ursb_pkg::RX_WAITHI;
                        else
                            rx_st <= ursb_pkg::RX_HUNT;
                    end
                end
                ursb_pkg::RX_WAITHI: if (ovs_tick && vote)
                    rx_st <= ursb_pkg::RX_HUNT;
                default: rx_st <= ursb_pkg::RX_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive buffer and flags
    // ------------------------------------------------------------
    wire full = (fifo_cnt == 2'h2);
    wire push = load_word && (!full || pop);
    wire ovr_evt = load_word && full && !pop;
    wire [1:0] wr_slot = pop ? fifo_cnt - 2'h2 + 2'h1 : fifo_cnt;
    wire rx_busy = (rx_st == ursb_pkg::RX_START && ovs_cnt > `URSB_OVS_MID)
        || rx_st == ursb_pkg::RX_DATA
        || (rx_st == ursb_pkg::RX_STOP && ovs_cnt <= `URSB_OVS_MID);

    always_ff @(posedge mclk_i) begin
        if (!rstn_i || !port_enable) begin
            fifo_cnt <= 2'h0;
            fifo[0] <= 12'h000;
            fifo[1] <= 12'h000;
            overrun_flag <= 1'b0;
            receiver_idle_flag <= 1'b1;
        end else begin
            if (pop)
                fifo[0] <= fifo[1];
            if (push)
                fifo[wr_slot[0]] <= load_val;
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
            // Set beats clear in the same cycle
            if (ovr_evt)
                overrun_flag <= 1'b1;
            else if (seq_rd_data)
                overrun_flag <= 1'b0;
            receiver_idle_flag <= ~rx_busy;
        end
    end

    // ------------------------------------------------------------
    // Transmit flags and break generator
    // ------------------------------------------------------------
    ursb_pkg::ursb_tx_t tx_st;
    logic [7:0] brk_hold;
    logic brk_armed;
    logic [3:0] tx_ovs;
    logic [3:0] tx_bits;
    logic tx_stop2;
    logic txe_irq_en;
    assign txe_irq_en = ctrl2[`URSB_C2_TEIE];
    // Break bits ride on the free-running tick count, so a break can
    // start up to one bit time after it is armed
    wire tx_bit_end = ovs_tick && tx_ovs == `URSB_OVS_LAST;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i || !port_enable) begin
            tx_st <= ursb_pkg::TX_IDLE;
            brk_hold <= 8'h00;
            brk_armed <= 1'b0;
            tx_ovs <= 4'h0;
            tx_bits <= 4'h0;
            tx_stop2 <= 1'b0;
            tx_o <= 1'b1;
            transmit_empty_flag <= 1'b1;
            transmitter_idle_flag <= 1'b1;
        end else begin
            if (ovs_tick)
                tx_ovs <= tx_ovs + 4'h1;
            // Data frames are not sent from here, so a data write only
            // clears the transmit flags; the word itself is dropped
            if (seq_wr_data) begin
                transmit_empty_flag <= 1'b0;
                transmitter_idle_flag <= 1'b0;
            end
            if (break_send_ctl && transmitter_idle_flag
                && brk_hold != baud_divisor + 8'h01)
                brk_hold <= brk_hold + 8'h01;
            else if (!break_send_ctl)
                brk_hold <= 8'h00;
            if (break_send_ctl && transmitter_idle_flag
                && brk_hold == baud_divisor + 8'h01)
                brk_armed <= 1'b1;
            case (tx_st)
                ursb_pkg::TX_IDLE: if (brk_armed && tx_bit_end) begin
                    tx_st <= ursb_pkg::TX_START;
                    tx_o <= 1'b0;
                end
                ursb_pkg::TX_START: if (tx_bit_end) begin
                    tx_st <= ursb_pkg::TX_BREAK;
                    tx_bits <= 4'h0;
                end
                ursb_pkg::TX_BREAK: if (tx_bit_end) begin
                    tx_bits <= tx_bits + 4'h1;
                    if (tx_bits == `URSB_BRK_BITS - 4'h1) begin
                        tx_bits <= 4'h0;
                        if (!break_send_ctl) begin
                            tx_st <= ursb_pkg::TX_STOP;
                            tx_o <= 1'b1;
                            tx_stop2 <= ctrl1[`URSB_C1_STOP2];
                        end
                    end
                end
                ursb_pkg::TX_STOP: if (tx_bit_end) begin
                    if (tx_stop2) begin
                        tx_stop2 <= 1'b0;
                    end else begin
                        tx_st <= ursb_pkg::TX_IDLE;
                        brk_armed <= 1'b0;
                        transmitter_idle_flag <= 1'b1;
                    end
                end
                default: tx_st <= ursb_pkg::TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register file, read data and interrupts
    // ------------------------------------------------------------
    wire [7:0] rx_word = avail ? fifo[0][7:0] : 8'h00;
    wire [7:0] ctrl1_rd = {ctrl1[7:2], avail & fifo[0][8], ctrl1[0]};
    wire [7:0] next_rdata = rd_stat ? status_word :
        rd_data ? rx_word :
        (rd_i && addr_i == `URSB_ADDR_CTRL1) ? ctrl1_rd :
        (rd_i && addr_i == `URSB_ADDR_CTRL2) ? ctrl2 :
        (rd_i && addr_i == `URSB_ADDR_DIV) ? baud_divisor : 8'h00;
    wire [7:0] next_ctrl1 = port_enable ? wdata_i :
        (wdata_i & 8'hFB);
    wire [7:0] next_ctrl2 = (wdata_i[`URSB_C1_EN] | ctrl1[`URSB_C1_EN]) ?
        wdata_i : wdata_i;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            ctrl1 <= `URSB_CTRL1_RST;
            ctrl2 <= `URSB_CTRL2_RST;
            baud_divisor <= `URSB_DIV_RST;
            rdata_o <= 8'h00;
            stat_seen <= 1'b0;
            rx_irq_o <= 1'b0;
            tx_irq_o <= 1'b0;
        end else begin
            rdata_o <= next_rdata;
            if (rd_stat)
                stat_seen <= 1'b1;
            else if (rd_data || wr_data)
                stat_seen <= 1'b0;
            if (wr_i && addr_i == `URSB_ADDR_CTRL1)
                ctrl1 <= next_ctrl1;
            else if (!port_enable)
                ctrl1[`URSB_C1_BRK] <= 1'b0;
            if (wr_i && addr_i == `URSB_ADDR_CTRL2)
                ctrl2 <= next_ctrl2;
            else if (!port_enable)
                ctrl2[7:6] <= 2'h0;
            if (wr_i && addr_i == `URSB_ADDR_DIV)
                baud_divisor <= wdata_i;
            // Noise rides on data-available, no own source
            rx_irq_o <= receive_irq_enable & (push | ovr_evt);
            // Break frames never count as a transmit event
            tx_irq_o <= txe_irq_en & transmit_empty_flag
                & ~brk_armed & port_enable;
        end
    end
endmodule : ursb_top

// file: include/ursb_defines.svh
// Constants for the serial receiver and break block
`ifndef URSB_DEFINES_SVH
`define URSB_DEFINES_SVH
`define URSB_ADDR_STATUS 4'h0
`define URSB_ADDR_DATA 4'h1
`define URSB_ADDR_CTRL1 4'h2
`define URSB_ADDR_CTRL2 4'h3
`define URSB_ADDR_DIV 4'h4
`define URSB_C1_EN 7
`define URSB_C1_NINE 6
`define URSB_C1_PAREN 5
`define URSB_C1_PODD 4
`define URSB_C1_STOP2 3
`define URSB_C1_BRK 2
`define URSB_C1_RX8 1
`define URSB_C1_TX8 0
`define URSB_C2_TXEN 7
`define URSB_C2_RECEIVE_ENABLE 6
`define URSB_C2_RIE 3
`define URSB_C2_TEIE 2
`define URSB_OVS_LAST 4'hF
`define URSB_OVS_MID 4'h7
`define URSB_BRK_BITS 4'hD
`define URSB_CTRL1_RST 8'h00
`define URSB_CTRL2_RST 8'h00
`define URSB_DIV_RST 8'h00
`endif

// file: include/ursb_pkg.sv
// Types for the serial receiver and break block
package ursb_pkg;
    typedef enum logic [2:0] {RX_OFF, RX_HUNT, RX_START, RX_DATA, RX_STOP,
        RX_WAITHI} ursb_rx_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BREAK, TX_STOP}
        ursb_tx_t;
endpackage : ursb_pkg

// file: test/ursb_remote.sv
// Remote serial device model on the receive and transmit lines
`timescale 1ns/100ps
module ursb_remote #(
    parameter int BIT_N = 32
) (
    // Clock
    input wire logic mclk_i,
    // Serial lines
    input wire logic tx_i,
    output logic rx_o
);
    int low_len = 0;
    int n = 0;
    initial rx_o = 1'b1;
    // Length of the last low stretch sent by the device
    always @(posedge mclk_i) begin
        if (!tx_i) begin
            n <= n + 1;
        end else if (n != 0) begin
            low_len <= n;
            n <= 0;
        end
    end
    // Start, nb bits LSB first, stop level, one idle bit; a glitch of
    // one tick lands on the first vote sample of bit 0 to mark noise
    task automatic send(input logic [8:0] w, input int nb,
            input logic stop, input bit glitch);
        @(posedge mclk_i);
        rx_o <= 1'b0;
        repeat (BIT_N) @(posedge mclk_i);
        for (int i = 0; i < nb; i++) begin
            rx_o <= w[i];
            repeat (BIT_N * 5 / 16) @(posedge mclk_i);
            if (glitch && i == 0) rx_o <= ~w[i];
            repeat (BIT_N / 16) @(posedge mclk_i);
            rx_o <= w[i];
            repeat (BIT_N * 10 / 16) @(posedge mclk_i);
        end
        rx_o <= stop;
        repeat (BIT_N) @(posedge mclk_i);
        rx_o <= 1'b1;
        repeat (BIT_N) @(posedge mclk_i);
    endtask : send
endmodule : ursb_remote

// file: test/ursb_top_props.sv
// Port checker for the serial receiver and break block
`timescale 1ns/100ps
module ursb_top_props (
    // Clock, reset and register port
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Serial pins and interrupts
    input wire logic rx_i,
    input wire logic tx_o,
    input wire logic rx_irq_o,
    input wire logic tx_irq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------
    // Shadows of the control bits seen on the bus
    // ------------------------------------------------
    logic en_q;
    logic rie_q;
    logic [7:0] div_q;
    int low_n;
    int high_n;
    int bit_n;
    assign bit_n = 16 * (int'(div_q) + 1);
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            en_q <= 1'b0;
            rie_q <= 1'b0;
            div_q <= 8'h00;
        end else if (wr_i && addr_i == 4'h2) begin
            en_q <= wdata_i[7];
        end else if (wr_i && addr_i == 4'h3) begin
            rie_q <= wdata_i[3];
        end else if (wr_i && addr_i == 4'h4) begin
            div_q <= wdata_i;
        end
    end
    // Run lengths of the output line; high run saturates
    always_ff @(posedge mclk_i) begin
        low_n <= (!rstn_i || tx_o) ? 0 : low_n + 1;
        high_n <= (!tx_o) ? 0 : (high_n < 99999 ? high_n + 1 : high_n);
    end
    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    AST_UNMAPPED_ZERO: assert property (
        rd_i && addr_i > 4'h4 |=> rdata_o == 8'h00)
        else $error("unmapped read returned data");
    AST_DIV_READBACK: assert property (
        rd_i && addr_i == 4'h4 |=> rdata_o == div_q)
        else $error("divisor read back differs");
    AST_DISABLED_STATUS: assert property (
        rd_i && addr_i == 4'h0 && !en_q |=> rdata_o == 8'h07)
        else $error("status of disabled port wrong");
    AST_RX_IRQ_PULSE: assert property (
        rx_irq_o |=> !rx_irq_o)
        else $error("receive interrupt longer than a pulse");
    AST_RX_IRQ_RIE: assert property (
        rx_irq_o |-> rie_q || $past(rie_q))
        else $error("receive interrupt while masked");
    AST_RX_IRQ_EN: assert property (
        rx_irq_o |-> en_q || $past(en_q))
        else $error("receive interrupt while port off");
    AST_BRK_NO_TXIRQ: assert property (
        !tx_o |-> !$rose(tx_irq_o))
        else $error("transmit interrupt raised by break");
    AST_BRK_LENGTH: assert property (
        $rose(tx_o) |-> low_n % (13 * bit_n) == bit_n)
        else $error("break low time not start plus 13N bits");
    AST_BRK_STOP: assert property (
        $fell(tx_o) |-> high_n >= bit_n)
        else $error("line high less than one bit before break");
    COV_BREAK_END: cover property ($rose(tx_o));
    COV_RX_IRQ: cover property (rx_irq_o);
    COV_DATA_READ: cover property (rd_i && addr_i == 4'h1);
endmodule : ursb_top_props
bind ursb_top ursb_top_props ursb_top_props_inst (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));

// file: test/ursb_top_test.sv
// Self-checking bench for the serial receiver and break block
`timescale 1ns/100ps
module ursb_top_test;
    localparam int DIV = 3;
    localparam int BIT = 16 * (DIV + 1);
    logic mclk_i, rstn_i, wr_i, rd_i, rx_i, tx_o, rx_irq_o, tx_irq_o;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    int n_errors = 0, comparisons = 0, n_irq = 0;
    ursb_top ursb_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o),
        .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
    ursb_remote #(.BIT_N(BIT)) ursb_remote_inst (.mclk_i(mclk_i),
        .tx_i(tx_o), .rx_o(rx_i));
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (rx_irq_o === 1'b1) n_irq <= n_irq + 1;
    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic give_up(input string what);
        n_errors++;
        $display("MISMATCH %s expected event seen timeout", what);
        report_and_stop;
    endtask : give_up
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rchk(input string what, input logic [3:0] a,
            input logic [7:0] m, e);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(what, rdata_o & m, e);
    endtask : rchk
    task automatic snd(input logic [8:0] w, input int nb = 8,
            input logic st = 1'b1, input bit g = 1'b0);
        ursb_remote_inst.send(w, nb, st, g);
    endtask : snd
    task automatic wait_irq(input int n);
        for (int k = 0; k < 20 * BIT && n_irq < n; k++) @(posedge mclk_i);
        if (n_irq != n) give_up("rx_irq count");
    endtask : wait_irq
    task automatic low_count(input int len, output int lows);
        lows = 0;
        repeat (len) begin
            @(posedge mclk_i);
            if (tx_o !== 1'b1) lows++;
        end
    endtask : low_count
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_reset_and_off;
        rchk("status", 4'h0, 8'hFF, 8'h07);
        rchk("ctrl1", 4'h2, 8'hFF, 8'h00);
        rchk("unmapped", 4'hF, 8'hFF, 8'h00);
        wr(4'h4, 8'(DIV));
        wr(4'h2, 8'h80);
        wr(4'h3, 8'h08);
        snd(9'h05A);
        chk("irq while rx off", 8'(n_irq), 8'h00);
    endtask : t_reset_and_off
    task automatic t_rx_words;
        wr(4'h3, 8'h48);
        fork
            snd(9'h0A5);
            begin
                repeat (4 * BIT) @(posedge mclk_i);
                rchk("idle in frame", 4'h0, 8'h04, 8'h00);
            end
        join
        wait_irq(1);
        snd(9'h03C);
        wait_irq(2);
        rchk("idle after", 4'h0, 8'h0C, 8'h04);
        rchk("word 1", 4'h1, 8'hFF, 8'hA5);
        rchk("status", 4'h0, 8'h7C, 8'h04);
        rchk("word 2", 4'h1, 8'hFF, 8'h3C);
        snd(9'h011);
        snd(9'h022);
        snd(9'h033);
        wait_irq(5);
        rchk("overrun", 4'h0, 8'h08, 8'h08);
        rchk("kept 1", 4'h1, 8'hFF, 8'h11);
        rchk("overrun clr", 4'h0, 8'h08, 8'h00);
        rchk("kept 2", 4'h1, 8'hFF, 8'h22);
    endtask : t_rx_words
    task automatic t_rx_errors;
        wr(4'h2, 8'hB0);
        snd(9'h003);
        wait_irq(6);
        rchk("odd parity", 4'h0, 8'h10, 8'h10);
        rchk("odd word", 4'h1, 8'hFF, 8'h03);
        wr(4'h2, 8'hA0);
        snd(9'h003);
        wait_irq(7);
        rchk("even parity", 4'h0, 8'h10, 8'h00);
        rchk("even word", 4'h1, 8'hFF, 8'h03);
        wr(4'h2, 8'h80);
        snd(9'h055, 8, 1'b0);
        wait_irq(8);
        rchk("framing", 4'h0, 8'h20, 8'h20);
        rchk("framed word", 4'h1, 8'hFF, 8'h55);
        snd(9'h0A5, 8, 1'b1, 1'b1);
        wait_irq(9);
        rchk("noise", 4'h0, 8'h40, 8'h40);
        rchk("noisy word", 4'h1, 8'hFF, 8'hA5);
        wr(4'h2, 8'hC0);
        snd(9'h1C3, 9);
        wait_irq(10);
        rchk("ninth bit", 4'h2, 8'h02, 8'h02);
        rchk("status", 4'h0, 8'h7C, 8'h04);
        rchk("nine low", 4'h1, 8'hFF, 8'hC3);
        wr(4'h2, 8'h80);
        snd(9'h000, 20, 1'b0);
        wait_irq(11);
        chk("one break word", 8'(n_irq), 8'd11);
        rchk("break flags", 4'h0, 8'h24, 8'h24);
        rchk("break data", 4'h1, 8'hFF, 8'h00);
        snd(9'h069);
        wait_irq(12);
        rchk("status", 4'h0, 8'h7C, 8'h04);
        rchk("after break", 4'h1, 8'hFF, 8'h69);
    endtask : t_rx_errors
    task automatic t_break_tx;
        int lows;
        wr(4'h3, 8'hCC);
        wr(4'h2, 8'h84);
        wr(4'h2, 8'h80);
        low_count(3 * BIT, lows);
        chk("short break", 8'(lows), 8'h00);
        chk("tx irq idle", 8'(tx_irq_o), 8'h01);
        wr(4'h2, 8'h84);
        for (int k = 0; k < 4 * BIT && tx_o; k++) @(posedge mclk_i);
        if (tx_o) give_up("break start");
        chk("tx irq in break", 8'(tx_irq_o), 8'h00);
        repeat (20 * BIT) @(posedge mclk_i);
        wr(4'h2, 8'h80);
        for (int k = 0; k < 30 * BIT && !tx_o; k++) @(posedge mclk_i);
        if (!tx_o) give_up("break end");
        @(posedge mclk_i);
        lows = ursb_remote_inst.low_len % (13 * BIT);
        chk("break length", 8'(lows == BIT), 8'h01);
        low_count(BIT, lows);
        chk("stop bits", 8'(lows), 8'h00);
        rchk("tx flags set", 4'h0, 8'h03, 8'h03);
        wr(4'h1, 8'h5A);
        rchk("tx flags clr", 4'h0, 8'h03, 8'h00);
        wr(4'h2, 8'h00);
        rchk("disabled", 4'h0, 8'hFF, 8'h07);
        rchk("ctrl2 off", 4'h3, 8'hC0, 8'h00);
        rchk("divisor", 4'h4, 8'hFF, 8'(DIV));
    endtask : t_break_tx
    initial begin
        rstn_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_reset_and_off();
        t_rx_words();
        t_rx_errors();
        t_break_tx();
        report_and_stop();
    end
endmodule : ursb_top_test
